// file: hw/abu_pkg.sv
package abu_pkg;
  // ************************************************************
  // Register map, one aligned 32-bit word each
  // ************************************************************
  localparam logic [7:0] ABU_OFF_SCR   = 8'h00;
  localparam logic [7:0] ABU_OFF_ADRH  = 8'h04;
  localparam logic [7:0] ABU_OFF_ADRL  = 8'h08;
  localparam logic [7:0] ABU_OFF_AUX   = 8'h0C;
  localparam logic [7:0] ABU_OFF_WST   = 8'h10;
  localparam logic [7:0] ABU_OFF_FLG   = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ABU_BIT_ENABLE  = 7;
  localparam int ABU_BIT_ACTIVE  = 6;
  localparam int ABU_BIT_WDOFF   = 0;
  localparam int ABU_BIT_WAITEX  = 1;
  localparam int ABU_BIT_FLGCLR  = 7;

  // ************************************************************
  // Reset values and constants
  // ************************************************************
  localparam logic [7:0]  ABU_RST_BYTE    = 8'h00;
  localparam logic [15:0] ABU_VEC_NORMAL  = 16'hFFFC;
  localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;
  localparam logic [7:0]  ABU_SWI_OPCODE  = 8'h83;
  localparam logic [1:0]  ABU_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  ABU_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ABU_ST_IDLE  = 3'b001,
    ABU_ST_PEND  = 3'b010,
    ABU_ST_BREAK = 3'b100
  } abu_state_t;
endpackage

// file: hw/abu_address_break_unit.sv
`timescale 1ns/1ps
// What this block does
// - Enabled address match on a CPU cycle raises a breakpoint request.
// - A break drives the software-interrupt opcode for the instruction register.
// - Break vector is FFFC normally and FEFC in monitor mode.
// - Writing one to the active bit forces a break without any match.
// - Match on an opcode fetch breaks at once, before that instruction runs.
// - Match on an operand waits until the instruction completes.
// - A forced break is taken at the next instruction boundary.
// - Enable bit 7 gates 16-bit matches; read/write, reset clears it.
// - Hardware sets the active bit on a match; reset clears it.
// - Return-from-interrupt during a break ends the break state.
// - Same address does not break again until the address is rewritten.
// - Address high and low registers form the compare value, reset zero.
// - Watchdog off bit holds the watchdog during break in monitor mode.
// - Wait-exit bit reads one when a break ended wait mode.
// - Other flags clear during break only when the clear-enable bit is set.
// - Timer counter freezes while a break is in progress.
// - No address-match break is triggered in wait or stop mode; a forced break still is.
module abu_address_break_unit
  import abu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic        cpu_opcode_fetch,
  input  wire logic        cpu_instr_boundary,
  input  wire logic        cpu_return_from_interrupt,
  input  wire logic        serial_monitor,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  output logic             breakpoint_request,
  output logic [7:0]       software_interrupt_opcode,
  output logic [15:0]      break_vector,
  output logic             break_state,
  output logic             watchdog_hold,
  output logic             flag_clear_allowed,
  output logic             timer_freeze
);

  // ************************************************************
  // Registers and state
  // ************************************************************
  abu_state_t  state;
  abu_state_t  next_state;
  logic        break_enable_bit;
  logic        break_active_bit;
  logic [7:0]  addr_high;
  logic [7:0]  addr_low;
  logic        watchdog_off_in_break;
  logic        wait_exit_by_break;
  logic        flag_clear_in_break_enable;
  logic        rearm_blocked;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ABU_OFF_SCR) || (a == ABU_OFF_ADRH) || (a == ABU_OFF_ADRL) ||
                (a == ABU_OFF_AUX) || (a == ABU_OFF_WST) || (a == ABU_OFF_FLG);
  endfunction

  // ************************************************************
  // Write channel decode
  // ************************************************************
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane = wr_fire && w_strb[0];
  wire wr_scr  = wr_lane && (aw_addr == ABU_OFF_SCR);
  wire wr_adrh = wr_lane && (aw_addr == ABU_OFF_ADRH);
  wire wr_adrl = wr_lane && (aw_addr == ABU_OFF_ADRL);
  wire wr_aux  = wr_lane && (aw_addr == ABU_OFF_AUX);
  wire wr_wst  = wr_lane && (aw_addr == ABU_OFF_WST);
  wire wr_flg  = wr_lane && (aw_addr == ABU_OFF_FLG);
  wire [7:0] wbyte = w_data[7:0];

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // ************************************************************
  // Break detection
  // ************************************************************
  wire [15:0] break_addr = {addr_high, addr_low};
  // The address bus is frozen in low-power modes, so matching is shut off there.
  wire addr_hit  = cpu_addr_valid && (cpu_addr == break_addr);
  wire match     = break_enable_bit && addr_hit && !wait_mode && !stop_mode &&
                   !rearm_blocked && (state != ABU_ST_BREAK);
  wire force_brk = wr_scr && wbyte[ABU_BIT_ACTIVE] && (state != ABU_ST_BREAK);
  wire take_now  = match && cpu_opcode_fetch;
  wire defer     = (match && !cpu_opcode_fetch) || force_brk;
  wire take_pend = (state == ABU_ST_PEND) && cpu_instr_boundary;
  wire next_req  = take_now || take_pend;

  always_comb begin
    next_state = state;
    case (state)
      ABU_ST_IDLE: begin
        if (take_now) begin
          next_state = ABU_ST_BREAK;
        end else if (defer) begin
          next_state = ABU_ST_PEND;
        end
      end
      ABU_ST_PEND: begin
        if (cpu_instr_boundary) begin
          next_state = ABU_ST_BREAK;
        end
      end
      ABU_ST_BREAK: begin
        if (cpu_return_from_interrupt) begin
          next_state = ABU_ST_IDLE;
        end
      end
      default: next_state = ABU_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ABU_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Break outputs
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      breakpoint_request        <= 1'b0;
      software_interrupt_opcode <= ABU_RST_BYTE;
      break_vector              <= ABU_VEC_NORMAL;
    end else begin
      breakpoint_request        <= next_req;
      software_interrupt_opcode <= next_req ? ABU_SWI_OPCODE : ABU_RST_BYTE;
      if (next_req) begin
        break_vector <= serial_monitor ? ABU_VEC_MONITOR : ABU_VEC_NORMAL;
      end
    end
  end

  assign break_state        = (state == ABU_ST_BREAK);
  assign timer_freeze       = break_state;
  assign watchdog_hold      = break_state && serial_monitor && watchdog_off_in_break;
  assign flag_clear_allowed = !break_state || flag_clear_in_break_enable;

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_enable_bit           <= 1'b0;
      break_active_bit           <= 1'b0;
      addr_high                  <= ABU_RST_BYTE;
      addr_low                   <= ABU_RST_BYTE;
      watchdog_off_in_break      <= 1'b0;
      wait_exit_by_break         <= 1'b0;
      flag_clear_in_break_enable <= 1'b0;
      rearm_blocked              <= 1'b0;
    end else begin
      if (wr_scr) begin
        break_enable_bit <= wbyte[ABU_BIT_ENABLE];
      end
      // A hardware match wins over a software clear in the same cycle.
      if (match || force_brk) begin
        break_active_bit <= 1'b1;
      end else if (wr_scr) begin
        break_active_bit <= wbyte[ABU_BIT_ACTIVE];
      end
      if (wr_adrh) begin
        addr_high <= wbyte;
      end
      if (wr_adrl) begin
        addr_low <= wbyte;
      end
      // Rewriting the address is what re-arms the comparator after a hit.
      if (match) begin
        rearm_blocked <= 1'b1;
      end else if (wr_adrh || wr_adrl) begin
        rearm_blocked <= 1'b0;
      end
      if (wr_aux) begin
        watchdog_off_in_break <= wbyte[ABU_BIT_WDOFF];
      end
      if (next_req && wait_mode) begin
        wait_exit_by_break <= 1'b1;
      end else if (wr_wst && !wbyte[ABU_BIT_WAITEX]) begin
        wait_exit_by_break <= 1'b0;
      end
      if (wr_flg) begin
        flag_clear_in_break_enable <= wbyte[ABU_BIT_FLGCLR];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  wire [7:0] rd_byte =
    (s_axi_araddr == ABU_OFF_SCR)  ? {break_enable_bit, break_active_bit, 6'h00} :
    (s_axi_araddr == ABU_OFF_ADRH) ? addr_high :
    (s_axi_araddr == ABU_OFF_ADRL) ? addr_low :
    (s_axi_araddr == ABU_OFF_AUX)  ? {7'h00, watchdog_off_in_break} :
    (s_axi_araddr == ABU_OFF_WST)  ? {6'h00, wait_exit_by_break, 1'b0} :
    (s_axi_araddr == ABU_OFF_FLG)  ? {flag_clear_in_break_enable, 7'h00} :
    ABU_RST_BYTE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= ABU_RST_BYTE;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ABU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ABU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking abu_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_OPCODE_MATCH_BREAKS: assert property (
    take_now |=> breakpoint_request && break_state)
    else $error("Opcode match did not raise a request next cycle.");

  AST_SWI_INJECT: assert property (
    breakpoint_request |-> software_interrupt_opcode == ABU_SWI_OPCODE)
    else $error("Request without the software-interrupt opcode.");

  AST_VECTOR_SELECT: assert property (
    breakpoint_request |-> break_vector == ($past(serial_monitor) ? ABU_VEC_MONITOR : ABU_VEC_NORMAL))
    else $error("Break vector does not follow monitor mode.");

  AST_FORCED_WAITS_BOUNDARY: assert property (
    (state == ABU_ST_PEND) && !cpu_instr_boundary |=> !breakpoint_request && (state == ABU_ST_PEND))
    else $error("Deferred break taken before the instruction boundary.");

  AST_FORCE_SETS_ACTIVE: assert property (
    force_brk |=> break_active_bit && (state == ABU_ST_PEND))
    else $error("Forced break did not set active and pend.");

  AST_MATCH_SETS_ACTIVE: assert property (
    match |=> break_active_bit && rearm_blocked)
    else $error("Match did not set the active bit.");

  AST_RTI_ENDS_BREAK: assert property (
    break_state && cpu_return_from_interrupt |=> !break_state && !timer_freeze)
    else $error("Return did not end the break state.");

  AST_NO_REARM: assert property (
    rearm_blocked && (state == ABU_ST_IDLE) |=> !breakpoint_request)
    else $error("Same address broke again without rewrite.");

  AST_LOWPOWER_NO_BREAK: assert property (
    (wait_mode || stop_mode) && (state == ABU_ST_IDLE) && !force_brk |=> !breakpoint_request)
    else $error("Break raised in a low-power mode.");

  AST_WATCHDOG_HOLD: assert property (
    watchdog_hold |-> break_state && serial_monitor && watchdog_off_in_break)
    else $error("Watchdog held outside monitor break.");

  AST_OPERAND_DEFERS: assert property (
    match && !cpu_opcode_fetch && (state == ABU_ST_IDLE) |=> !breakpoint_request && (state == ABU_ST_PEND))
    else $error("Operand match broke before the instruction finished.");

  AST_BOUNDARY_BREAKS: assert property (
    (state == ABU_ST_PEND) && cpu_instr_boundary |=> breakpoint_request && break_state)
    else $error("Pending break not taken at the instruction boundary.");

  AST_ENABLE_GATES: assert property (
    !break_enable_bit && (state == ABU_ST_IDLE) |=> !breakpoint_request)
    else $error("Break raised while breaks are disabled.");

  AST_HIT_REQUESTS: assert property (
    break_enable_bit && addr_hit && cpu_opcode_fetch && !wait_mode && !stop_mode && !rearm_blocked &&
    (state == ABU_ST_IDLE) |=> breakpoint_request)
    else $error("Enabled opcode hit did not raise a request.");

  AST_REQUEST_PULSE: assert property (
    breakpoint_request |=> !breakpoint_request)
    else $error("Breakpoint request stood longer than one cycle.");

  AST_ACTIVE_CLEAR: assert property (
    wr_scr && !wbyte[ABU_BIT_ACTIVE] && !match |=> !break_active_bit)
    else $error("Software clear of the active bit was lost.");

  AST_WAIT_EXIT_SET: assert property (
    breakpoint_request && $past(wait_mode) |-> wait_exit_by_break)
    else $error("Break out of wait mode did not set the wait-exit bit.");

  AST_FLAG_CLEAR_GATE: assert property (
    break_state && !flag_clear_in_break_enable |-> !flag_clear_allowed)
    else $error("Flag clearing allowed in break without the enable bit.");

  AST_TIMER_FROZEN: assert property (
    breakpoint_request |-> timer_freeze)
    else $error("Timer not frozen when the break was taken.");

  AST_WATCHDOG_FREE: assert property (
    !break_state |-> !watchdog_hold)
    else $error("Watchdog held outside a break.");

  // ************************************************************
  // Cover points
  // ************************************************************

  COV_OPCODE_BREAK: cover property (take_now ##1 breakpoint_request ##[1:20] cpu_return_from_interrupt);
  COV_OPERAND_BREAK: cover property (match && !cpu_opcode_fetch ##[1:10] breakpoint_request);
  COV_FORCED_BREAK: cover property (force_brk ##[1:10] breakpoint_request);
  COV_MONITOR_VECTOR: cover property (breakpoint_request && break_vector == ABU_VEC_MONITOR);
  COV_WAIT_EXIT: cover property (breakpoint_request && wait_exit_by_break);

endmodule // abu_address_break_unit

// file: verif/abu_cpu_model.sv
`timescale 1ns/1ps
// ****************************************
// CPU stand-in: loops over 64 bytes of two-byte instructions.
// ****************************************
module abu_cpu_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic        svc_done,
  input  wire logic        break_state,
  output logic [15:0]      cpu_addr,
  output logic             cpu_addr_valid,
  output logic             cpu_opcode_fetch,
  output logic             cpu_instr_boundary,
  output logic             cpu_return_from_interrupt
);
  logic [5:0] pc;
  // A halted bus inverts its address every cycle with valid low, so a stale value never looks valid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc                        <= 6'h00;
      cpu_addr                  <= 16'h0000;
      cpu_addr_valid            <= 1'h0;
      cpu_opcode_fetch          <= 1'h0;
      cpu_instr_boundary        <= 1'h0;
      cpu_return_from_interrupt <= 1'h0;
    end else begin
      cpu_return_from_interrupt <= break_state & svc_done & ~cpu_return_from_interrupt;
      if (run && !break_state) begin
        pc                 <= pc + 6'h1;
        cpu_addr           <= {10'h000, pc};
        cpu_addr_valid     <= 1'h1;
        cpu_opcode_fetch   <= ~pc[0];
        cpu_instr_boundary <= ~pc[0];
      end else begin
        cpu_addr           <= ~cpu_addr;
        cpu_addr_valid     <= 1'h0;
        cpu_opcode_fetch   <= 1'h0;
        cpu_instr_boundary <= 1'h0;
      end
    end
  end
endmodule // abu_cpu_model

// file: verif/address_break_unit_tb.sv
`timescale 1ns/1ps
module address_break_unit_tb
  import abu_pkg::*;
;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        serial_monitor = 1'h0;
  logic        wait_mode = 1'h0;
  logic        stop_mode = 1'h0;
  logic        run = 1'h0;
  logic        svc_done = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] cpu_addr, break_vector;
  logic [7:0]  software_interrupt_opcode;
  logic        cpu_addr_valid, cpu_opcode_fetch, cpu_instr_boundary, cpu_return_from_interrupt;
  logic        breakpoint_request, break_state, watchdog_hold, flag_clear_allowed, timer_freeze;
  logic [33:0] q_rd[$];
  logic [32:0] q_bk[$];
  logic [1:0]  q_wr[$];
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] rnd = 32'h4A3B;

  always #50 aclk = ~aclk;
  abu_address_break_unit abu_address_break_unit_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid),
    .cpu_opcode_fetch(cpu_opcode_fetch),
    .cpu_instr_boundary(cpu_instr_boundary),
    .cpu_return_from_interrupt(cpu_return_from_interrupt),
    .serial_monitor(serial_monitor),
    .wait_mode(wait_mode),
    .stop_mode(stop_mode),
    .breakpoint_request(breakpoint_request),
    .software_interrupt_opcode(software_interrupt_opcode),
    .break_vector(break_vector),
    .break_state(break_state),
    .watchdog_hold(watchdog_hold),
    .flag_clear_allowed(flag_clear_allowed),
    .timer_freeze(timer_freeze)
  );
  abu_cpu_model abu_cpu_model_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .svc_done(svc_done),
    .break_state(break_state),
    .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid),
    .cpu_opcode_fetch(cpu_opcode_fetch),
    .cpu_instr_boundary(cpu_instr_boundary),
    .cpu_return_from_interrupt(cpu_return_from_interrupt)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fin(input string nm);
    $display("Test done: %s", nm);
  endtask
  // Ready flags are sampled at the falling edge so the decision never races the rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw, w, b;
    q_wr.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ar, r;
    q_rd.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r = 1'h0;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic arm(input logic [15:0] a, input logic [7:0] aux, input logic [7:0] flg, input logic [7:0] scr);
    run <= 1'h0;
    wr(ABU_OFF_AUX, aux, ABU_RESP_OKAY);
    wr(ABU_OFF_FLG, flg, ABU_RESP_OKAY);
    wr(ABU_OFF_ADRH, a[15:8], ABU_RESP_OKAY);
    wr(ABU_OFF_ADRL, a[7:0], ABU_RESP_OKAY);
    wr(ABU_OFF_SCR, scr, ABU_RESP_OKAY);
  endtask
  task automatic go(input int n);
    run <= 1'h1;
    repeat (n) @(posedge aclk);
  endtask
  task automatic svc_brk(input logic aux0, input logic flg7);
    int n;
    n = 0;
    while (break_state !== 1'h1 && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk("timer freeze", 34'(timer_freeze), 34'h1);
    chk("watchdog hold", 34'(watchdog_hold), 34'(aux0 & serial_monitor));
    chk("flag clear", 34'(flag_clear_allowed), 34'(flg7));
    rd(ABU_OFF_SCR, 34'h0C0);
    wr(ABU_OFF_SCR, 8'h80, ABU_RESP_OKAY);
    svc_done <= 1'h1;
    n = 0;
    while (break_state !== 1'h0 && n < 50) begin
      @(negedge aclk);
      n++;
    end
    chk("freeze after return", 34'(timer_freeze), 34'h0);
    chk("flag clear after return", 34'(flag_clear_allowed), 34'h1);
    chk("watchdog after return", 34'(watchdog_hold), 34'h0);
    @(posedge aclk);
    svc_done <= 1'h0;
  endtask

  // ****************************************
  // Result monitor
  // ****************************************
  always @(negedge aclk) begin
    logic [32:0] e;
    if (aresetn && s_axi_bvalid && s_axi_bready)
      chk("bresp", 34'(s_axi_bresp), q_wr.size() > 0 ? 34'(q_wr.pop_front()) : 34'hX);
    if (aresetn && s_axi_rvalid && s_axi_rready)
      chk("read", {s_axi_rresp, s_axi_rdata}, q_rd.size() > 0 ? q_rd.pop_front() : 34'hX);
    if (aresetn && breakpoint_request) begin
      e = q_bk.size() > 0 ? q_bk.pop_front() : 33'hX;
      chk("opcode", 34'(software_interrupt_opcode), 34'(ABU_SWI_OPCODE));
      chk("vector", 34'(break_vector), 34'(e[31:16]));
      if (e[32] !== 1'h0) chk("break address", 34'(cpu_addr), 34'(e[15:0]));
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [15:0] a;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 34'h0);
    rd(8'h18, {ABU_RESP_SLVERR, 32'h0});
    wr(8'h18, 8'h5A, ABU_RESP_SLVERR);
    rnd = lfsr(rnd);
    wr(ABU_OFF_ADRH, rnd[7:0], ABU_RESP_OKAY);
    rd(ABU_OFF_ADRH, 34'(rnd[7:0]));
    wr(ABU_OFF_ADRL, rnd[15:8], ABU_RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(ABU_OFF_ADRL, ~rnd[15:8], ABU_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ABU_OFF_ADRL, 34'(rnd[15:8]));
    wr(ABU_OFF_AUX, 8'hFF, ABU_RESP_OKAY);
    rd(ABU_OFF_AUX, 34'h001);
    wr(ABU_OFF_FLG, 8'hFF, ABU_RESP_OKAY);
    rd(ABU_OFF_FLG, 34'h080);
    fin("registers");
    // Any request in these runs meets an empty queue and is reported.
    for (int j = 0; j < 4; j++) begin
      rnd = lfsr(rnd);
      // Modes change only once the CPU stand-in is idle, so its last address never meets a fresh mode.
      arm({7'h00, j == 3, 2'h0, rnd[5:0]}, 8'h00, 8'h00, j == 2 ? 8'h00 : 8'h80);
      wait_mode <= (j == 0);
      stop_mode <= (j == 1);
      go(150);
      fin("no break");
    end
    wait_mode <= 1'h0;
    stop_mode <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      a = {10'h000, rnd[5:1], i[1]};
      serial_monitor <= i[0];
      arm(a, {7'h00, i[1]}, {i[0] ^ i[1], 7'h00}, 8'h80);
      q_bk.push_back({1'h1, i[0] ? ABU_VEC_MONITOR : ABU_VEC_NORMAL, 10'h000,
                      6'(a[5:0] + (a[0] ? 6'h2 : 6'h1))});
      go(1);
      svc_brk(i[1], i[0] ^ i[1]);
      go(150);
      fin("address break");
    end
    serial_monitor <= 1'h0;
    wait_mode <= 1'h1;
    arm(16'h0100, 8'h00, 8'h00, 8'hC0);
    repeat (20) @(posedge aclk);
    q_bk.push_back({1'h0, ABU_VEC_NORMAL, 16'h0000});
    go(1);
    svc_brk(1'h0, 1'h0);
    rd(ABU_OFF_WST, 34'h002);
    wr(ABU_OFF_WST, 8'h00, ABU_RESP_OKAY);
    rd(ABU_OFF_WST, 34'h000);
    wait_mode <= 1'h0;
    go(150);
    fin("forced break");
    give_verdict();
  end
endmodule // address_break_unit_tb
